/* File: rtl/sec_eeprom.sv */
// serial eeprom command interface: 256 x 16 array behind a four-wire
// select / serial clock / serial in / serial out port.
// assumes: clk_sys_in free-running at 100 MHz; serial_clock_in made by the
// master and idle outside frames; select_in rises well before the first
// serial clock edge and is low for at least 1 us between frames.
//
// What this block does
// - after select rises, leading zeros are skipped; first one is the start bit
// - eight address bits follow; read, write, erase use all eight
// - opcode 00 takes instruction from top address bits: 11,01,00,10
// - opcode 10 reads, 01 writes, 11 erases one addressed word
// - write and write-all carry sixteen data bits, msb first both directions
// - read loads the word into a shifter, sends one zero, then sixteen bits
// - read output changes only after serial clock rising edges
// - write-enable latch clear at power-on, held until disable instruction
// - enable and disable act at the select falling edge only
// - reads work whatever the write-enable latch holds
// - write and write-all accepted only while writes are enabled
// - programming starts at the select fall after the last bit
// - device is busy and refuses instructions while programming runs
// - with select high, output shows low while busy, high when done
// - output floats while select low; select toggling leaves programming alone
// - after ready is shown, a clocked start bit floats the output again
// - write-all programs every word with the given pattern at once
// - erase sets the addressed word to ones; erase-all sets every word
// - select low ends the frame and drops any partial instruction
// - select low interval resets all link-side state; write-enable latch and status display keep theirs
`timescale 1ns/1ps

module sec_eeprom #(
    parameter int unsigned PROG_CYCLES = sec_pkg::PROG_CYCLES_DEF
) (
    input  wire logic clk_sys_in,
    input  wire logic rst_b_in,
    input  wire logic select_in,
    input  wire logic serial_clock_in,
    input  wire logic serial_in,
    output logic      serial_out_out,
    output logic      serial_out_en_b_out
);
    import sec_pkg::*;

    // storage, written only in the system domain
    logic [15:0]       mem [WORDS];

    // link domain
    logic              link_rst_b;
    sec_lstate_t       lstate;
    logic [4:0]        bit_cnt;
    logic [1:0]        opcode;
    sec_pkt_t          rx_pkt;
    logic [7:0]        next_addr;
    sec_cmd_t          next_cmd;
    logic [15:0]       rd_shift;
    logic              rd_bit;
    logic              rd_drive;
    logic              started;
    logic              cmd_valid;
    logic              excess;

    // system domain
    logic              sel_s1, sel_s2, sel_s3;
    logic              cv_s1, cv_s2;
    logic              exc_s1, exc_s2;
    logic              st_s1, st_s2, st_s3;
    logic              rdb_s1, rdb_s2;
    logic              rdd_s1, rdd_s2;
    logic              sel_fall, sel_rise, st_rise;
    logic              armed;
    sec_pkt_t          held_pkt;
    sec_pkt_t          prog_pkt;
    logic              exec;
    logic              prog_start;
    logic              prog_done;
    logic              wr_enabled;
    logic              busy;
    logic [20:0]       prog_cnt;
    logic              status_mode;
    logic              all_op;
    logic              erase_op;

    // select low holds the whole link side in reset; the link clock is idle
    // then, so only the async path can clear it
    assign link_rst_b = rst_b_in & select_in;

    // instruction decode from opcode and the top address bits
    function automatic sec_cmd_t decode_cmd(input logic [1:0] opc, input logic [7:0] adr);
        sec_cmd_t c;
        c = cmd_none;
        case (opc)
            OPC_READ:  c = cmd_read;
            OPC_WRITE: c = cmd_write;
            OPC_ERASE: c = cmd_erase;
            default:
            begin
                case (adr[7:6])
                    SUB_WR_EN:     c = cmd_wr_enable;
                    SUB_PROG_ALL:  c = cmd_prog_all;
                    SUB_WR_DIS:    c = cmd_wr_disable;
                    default:       c = cmd_erase_all;
                endcase
            end
        endcase
        return c;
    endfunction : decode_cmd

    assign next_addr = {rx_pkt.addr[6:0], serial_in};
    assign next_cmd  = decode_cmd(opcode, next_addr);

    // link receive sequencer, one step per serial clock rising edge
    always_ff @(posedge serial_clock_in or negedge link_rst_b)
    begin
        if (!link_rst_b)
        begin
            lstate    <= ls_idle;
            bit_cnt   <= CNT_RESET;
            started   <= 1'b0;
            cmd_valid <= 1'b0;
            excess    <= 1'b0;
        end
        else
        begin
            case (lstate)
                ls_idle:
                begin
                    if (serial_in)
                    begin
                        lstate  <= ls_opcode;
                        started <= 1'b1;
                        bit_cnt <= CNT_RESET;
                    end
                end
                ls_opcode:
                begin
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == OPC_LAST)
                    begin
                        lstate  <= ls_addr;
                        bit_cnt <= CNT_RESET;
                    end
                end
                ls_addr:
                begin
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == ADDR_LAST)
                    begin
                        bit_cnt <= CNT_RESET;
                        if (next_cmd == cmd_read)
                            lstate <= ls_read;
                        else if (next_cmd == cmd_write || next_cmd == cmd_prog_all)
                            lstate <= ls_data;
                        else
                        begin
                            lstate    <= ls_done;
                            cmd_valid <= 1'b1;
                        end
                    end
                end
                ls_data:
                begin
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == DATA_LAST)
                    begin
                        lstate    <= ls_done;
                        cmd_valid <= 1'b1;
                    end
                end
                ls_read:
                    lstate <= ls_read;
                ls_done:
                begin
                    // an extra edge means select did not fall in time
                    cmd_valid <= 1'b0;
                    excess    <= 1'b1;
                    lstate    <= ls_skip;
                end
                default:
                    lstate <= ls_skip;
            endcase
        end
    end

    // opcode, address and data shifters, msb first
    always_ff @(posedge serial_clock_in or negedge link_rst_b)
    begin
        if (!link_rst_b)
        begin
            opcode <= OPC_SUB;
            rx_pkt <= PKT_RESET;
        end
        else
        begin
            if (lstate == ls_opcode)
                opcode <= {opcode[0], serial_in};
            if (lstate == ls_addr)
                rx_pkt.addr <= next_addr;
            if (lstate == ls_addr && bit_cnt == ADDR_LAST)
                rx_pkt.cmd <= next_cmd;
            if (lstate == ls_data)
                rx_pkt.data <= {rx_pkt.data[14:0], serial_in};
        end
    end

    // read shifter; the array word is static here because reads are only
    // meaningful outside a programming cycle
    always_ff @(posedge serial_clock_in or negedge link_rst_b)
    begin
        if (!link_rst_b)
        begin
            rd_shift <= DATA_RESET;
            rd_bit   <= 1'b0;
            rd_drive <= 1'b0;
        end
        else if (lstate == ls_read)
        begin
            rd_drive <= 1'b1;
            if (!rd_drive)
            begin
                rd_bit   <= 1'b0;
                rd_shift <= mem[rx_pkt.addr];
            end
            else
            begin
                rd_bit   <= rd_shift[15];
                rd_shift <= {rd_shift[14:0], 1'b0};
            end
        end
    end

    // crossings into the system clock: levels through two flip-flops
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
            sel_s3 <= 1'b0;
            cv_s1  <= 1'b0;
            cv_s2  <= 1'b0;
            exc_s1 <= 1'b0;
            exc_s2 <= 1'b0;
            st_s1  <= 1'b0;
            st_s2  <= 1'b0;
            st_s3  <= 1'b0;
            rdb_s1 <= 1'b0;
            rdb_s2 <= 1'b0;
            rdd_s1 <= 1'b0;
            rdd_s2 <= 1'b0;
        end
        else
        begin
            sel_s1 <= select_in;
            sel_s2 <= sel_s1;
            sel_s3 <= sel_s2;
            cv_s1  <= cmd_valid;
            cv_s2  <= cv_s1;
            exc_s1 <= excess;
            exc_s2 <= exc_s1;
            st_s1  <= started;
            st_s2  <= st_s1;
            st_s3  <= st_s2;
            rdb_s1 <= rd_bit;
            rdb_s2 <= rdb_s1;
            rdd_s1 <= rd_drive;
            rdd_s2 <= rdd_s1;
        end
    end

    assign sel_fall   = sel_s3 & ~sel_s2;
    assign sel_rise   = sel_s2 & ~sel_s3;
    assign st_rise    = st_s2 & ~st_s3;
    assign exec       = sel_fall & armed & ~busy;
    assign prog_start = exec & wr_enabled & (held_pkt.cmd == cmd_write || held_pkt.cmd == cmd_prog_all
                        || held_pkt.cmd == cmd_erase || held_pkt.cmd == cmd_erase_all);
    assign prog_done  = busy & (prog_cnt == PROG_CNT_RESET);
    assign all_op     = (prog_pkt.cmd == cmd_prog_all) | (prog_pkt.cmd == cmd_erase_all);
    assign erase_op   = (prog_pkt.cmd == cmd_erase) | (prog_pkt.cmd == cmd_erase_all);

    // complete instruction waits for the select fall; copy the fields once,
    // when the valid level is first seen: select low clears them on the link
    // side two cycles before the synchronised valid drops
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            armed    <= 1'b0;
            held_pkt <= PKT_RESET;
        end
        else
        begin
            if (sel_rise || sel_fall || exc_s2)
                armed <= 1'b0;
            else if (cv_s2 && sel_s2 && !armed)
            begin
                armed    <= 1'b1;
                held_pkt <= rx_pkt;
            end
        end
    end

    // write-enable latch
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            wr_enabled <= 1'b0;
        else if (exec && held_pkt.cmd == cmd_wr_enable)
            wr_enabled <= 1'b1;
        else if (exec && held_pkt.cmd == cmd_wr_disable)
            wr_enabled <= 1'b0;
    end

    // self-timed programming cycle; select toggling does not touch it
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            busy     <= 1'b0;
            prog_cnt <= PROG_CNT_RESET;
            prog_pkt <= PKT_RESET;
        end
        else if (prog_start)
        begin
            busy     <= 1'b1;
            prog_cnt <= PROG_CNT_W'(PROG_CYCLES - 1);
            prog_pkt <= held_pkt;
        end
        else if (busy)
        begin
            if (prog_done)
                busy <= 1'b0;
            else
                prog_cnt <= prog_cnt - 21'h000001;
        end
    end

    // status display lasts from programming start until a start bit is seen
    // after ready; a start bit sent while busy does not clear it
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            status_mode <= 1'b0;
        else if (prog_start)
            status_mode <= 1'b1;
        else if (!busy && st_rise)
            status_mode <= 1'b0;
    end

    // pin drivers; the enable is low while the pin is driven
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            serial_out_out      <= 1'b0;
            serial_out_en_b_out <= 1'b1;
        end
        else
        begin
            serial_out_en_b_out <= ~(sel_s2 & (status_mode | rdd_s2));
            serial_out_out      <= status_mode ? ~busy : rdb_s2;
        end
    end

    // array entries, updated at the end of the programming cycle
    for (genvar g = 0; g < WORDS; g++)
    begin : g_word
        always_ff @(posedge clk_sys_in or negedge rst_b_in)
        begin
            if (!rst_b_in)
                mem[g] <= ERASED_WORD;
            else if (prog_done && (all_op || prog_pkt.addr == 8'(g)))
                mem[g] <= erase_op ? ERASED_WORD : prog_pkt.data;
        end
    end

    // checks
    sequence s_sel_fall;
        sel_s2 ##1 !sel_s2;
    endsequence

    a_hiz_deselect: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        !sel_s2 |=> serial_out_en_b_out)
        else $error("serial out driven while deselected");

    a_status_busy: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (sel_s2 && status_mode && busy) |=> (!serial_out_en_b_out && !serial_out_out))
        else $error("busy status not shown as low");

    a_prog_start: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (s_sel_fall ##0 (armed && !busy && wr_enabled && held_pkt.cmd == cmd_write)) |=> busy)
        else $error("write did not start programming at select fall");

    a_locked_drop: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (s_sel_fall ##0 (armed && !busy && !wr_enabled)) |=> !busy)
        else $error("programming started while writes disabled");

    a_busy_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (busy && prog_cnt != PROG_CNT_RESET) |=> (busy && prog_cnt == $past(prog_cnt) - 21'h000001))
        else $error("programming cycle cut short");

    a_wel_at_fall: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $changed(wr_enabled) |-> $past(sel_fall && armed))
        else $error("write-enable latch moved outside select fall");

    a_wel_keeps: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (wr_enabled && !(exec && held_pkt.cmd == cmd_wr_disable)) |=> wr_enabled)
        else $error("write-enable latch lost without disable");

    a_erase_all: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (prog_done && prog_pkt.cmd == cmd_erase_all) |=> (mem[0] == ERASED_WORD && mem[255] == ERASED_WORD))
        else $error("erase-all left a word not all ones");

    a_ready_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (status_mode && !busy && st_rise && !prog_start) |=> ##1 (serial_out_en_b_out || rdd_s2))
        else $error("ready status not cleared by start bit");

    a_start_bit: assert property (@(posedge serial_clock_in) disable iff (!link_rst_b)
        (lstate == ls_idle) |=> (lstate == (($past(serial_in)) ? ls_opcode : ls_idle)))
        else $error("start bit not recognised");

    a_read_dummy: assert property (@(posedge serial_clock_in) disable iff (!link_rst_b)
        $rose(rd_drive) |-> (!rd_bit && rd_shift == mem[rx_pkt.addr]))
        else $error("read did not lead with a zero dummy bit");

endmodule : sec_eeprom

/* File: shared/sec_pkg.sv */
// constants, command codes and the command carrier for the serial eeprom
// command interface; shared by the design and by anything that drives it
package sec_pkg;

    // array geometry
    localparam int unsigned WORD_W    = 16;
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned WORDS     = 256;
    localparam int unsigned OPC_W     = 2;

    // last bit index of each serial field, counting link clock edges from zero
    localparam logic [4:0] OPC_LAST   = 5'h01;
    localparam logic [4:0] ADDR_LAST  = 5'h07;
    localparam logic [4:0] DATA_LAST  = 5'h0F;

    // opcode field and the sub-codes carried in the top two address bits
    localparam logic [1:0] OPC_SUB    = 2'h0;
    localparam logic [1:0] OPC_WRITE  = 2'h1;
    localparam logic [1:0] OPC_READ   = 2'h2;
    localparam logic [1:0] OPC_ERASE  = 2'h3;
    localparam logic [1:0] SUB_WR_DIS = 2'h0;
    localparam logic [1:0] SUB_PROG_ALL = 2'h1;
    localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
    localparam logic [1:0] SUB_WR_EN  = 2'h3;

    // reset and erased values
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [15:0] DATA_RESET  = 16'h0000;
    localparam logic [7:0]  ADDR_RESET  = 8'h00;
    localparam logic [4:0]  CNT_RESET   = 5'h00;

    // self-timed programming cycle
    localparam int unsigned SYS_CLK_MHZ        = 100;
    localparam int unsigned PROGRAM_CYCLE_TIME_US = 15000;
    localparam int unsigned PROG_CYCLES_DEF    = PROGRAM_CYCLE_TIME_US * SYS_CLK_MHZ;
    localparam int unsigned PROG_CNT_W         = 21;
    localparam logic [20:0] PROG_CNT_RESET     = 21'h000000;

    // decoded instructions
    typedef enum logic [2:0] {
        cmd_none      = 3'b000,
        cmd_read      = 3'b001,
        cmd_wr_enable = 3'b010,
        cmd_write     = 3'b011,
        cmd_prog_all  = 3'b100,
        cmd_wr_disable = 3'b101,
        cmd_erase     = 3'b110,
        cmd_erase_all = 3'b111
    } sec_cmd_t;

    // link side receive states
    typedef enum logic [2:0] {
        ls_idle   = 3'b000,
        ls_opcode = 3'b001,
        ls_addr   = 3'b010,
        ls_data   = 3'b011,
        ls_read   = 3'b100,
        ls_done   = 3'b101,
        ls_skip   = 3'b110
    } sec_lstate_t;

    // one received instruction with its operands
    typedef struct packed {
        sec_cmd_t          cmd;
        logic [7:0]        addr;
        logic [15:0]       data;
    } sec_pkt_t;

    localparam sec_pkt_t PKT_RESET = '{cmd: cmd_none, addr: ADDR_RESET, data: DATA_RESET};

endpackage : sec_pkg

/* File: dv/sec_master.sv */
// bus master model for the serial eeprom command interface: makes select,
// link clock and serial data, and samples the data output pin.
// assumes clk_sys_in at 100 MHz; the link clock stands still outside frames.
`timescale 1ns/1ps

module sec_master (
    input  wire logic clk_sys_in,
    input  wire logic dout_in,
    input  wire logic dout_en_b_in,
    output logic      select_out,
    output logic      sclk_out,
    output logic      sdata_out
);
    import sec_pkg::*;

    // idle levels at time zero
    initial
    begin
        select_out = 1'h0;
        sclk_out = 1'h0;
        sdata_out = 1'h0;
    end

    // one link clock of 2 us; a floating pin reads as unknown so it never matches
    task automatic clk_bit(input logic din, output logic dout);
        sdata_out = din;
        #1000;
        sclk_out = 1'h1;
        #1000;
        dout = dout_en_b_in ? 1'hx : dout_in;
        sclk_out = 1'h0;
    endtask : clk_bit

    // offset 2 ns from the system edge so no race with the device's sampling
    task automatic open_frame();
        @(posedge clk_sys_in);
        #2;
        if (!select_out)
        begin
            select_out = 1'h1;
            #300;
        end
    endtask : open_frame

    // select drops before any further link edge; data line is no longer held
    task automatic close_frame();
        #200;
        select_out = 1'h0;
        sdata_out = ~sdata_out;
        #1200;
    endtask : close_frame

    // sends the low n bits of a frame, msb first, after lz leading zeros
    task automatic send(input logic [26:0] bits, input int n, input int lz);
        logic d;
        open_frame();
        repeat (lz) clk_bit(1'h0, d);
        for (int i = n - 1; i >= 0; i--)
            clk_bit(bits[i], d);
        close_frame();
    endtask : send

    // word read: st is the enable level just after the start bit
    task automatic read_word(input logic [7:0] addr, input int lz, output logic st, output logic [16:0] got);
        logic        d;
        logic [10:0] f;
        f = {1'h1, OPC_READ, addr};
        open_frame();
        repeat (lz) clk_bit(1'h0, d);
        for (int i = 10; i >= 0; i--)
        begin
            clk_bit(f[i], d);
            if (i == 10)
                st = dout_en_b_in;
        end
        for (int i = 16; i >= 0; i--)
        begin
            clk_bit(1'h0, d);
            got[i] = d;
        end
        close_frame();
    endtask : read_word

    // raise select, take the first status, then wait for ready; select stays high
    task automatic poll(input int bound, output logic en_b, output logic lvl, output int cyc);
        open_frame();
        en_b = dout_en_b_in;
        lvl = dout_in;
        cyc = 0;
        while (!(dout_en_b_in === 1'h0 && dout_in === 1'h1) && cyc < bound)
        begin
            @(posedge clk_sys_in);
            cyc++;
        end
    endtask : poll
endmodule : sec_master

/* File: dv/sec_eeprom_bench.sv */
// self-checking bench for sec_eeprom; a memory image here predicts reads.
// assumes sec_master drives the link; programming is shortened to PROG cycles.
`timescale 1ns/1ps

module sec_eeprom_bench;
    import sec_pkg::*;
    localparam int unsigned PROG  = 4000;
    localparam int unsigned LIMIT = 99000;
    logic        clk_sys = 1'h0;
    logic        rst_b = 1'h0;
    wire         select;
    wire         sclk;
    wire         sdata;
    wire         dout;
    wire         dout_en_b;
    int          bad_count = 0;
    int          compares = 0;
    int          cycles = 0;
    logic [31:0] lfsr = 32'h6931335B;
    logic [7:0]  a;
    logic [15:0] d;
    logic        e;
    logic        l;
    int          c;
    logic [15:0] mem [WORDS];

    // system clock
    always #5 clk_sys = ~clk_sys;

    sec_eeprom #(.PROG_CYCLES(PROG)) DUT (.clk_sys_in(clk_sys), .rst_b_in(rst_b), .select_in(select),
        .serial_clock_in(sclk), .serial_in(sdata), .serial_out_out(dout), .serial_out_en_b_out(dout_en_b));
    sec_master M (.clk_sys_in(clk_sys), .dout_in(dout), .dout_en_b_in(dout_en_b), .select_out(select),
        .sclk_out(sclk), .sdata_out(sdata));

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand

    task automatic pick();
        lfsr = next_rand(lfsr);
        a = lfsr[7:0];
        d = lfsr[23:8];
    endtask : pick

    task automatic fill(input logic [15:0] v);
        foreach (mem[i])
            mem[i] = v;
    endtask : fill

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // frame is start bit, opcode, address, data, cut to its first n bits
    task automatic do_cmd(input logic [1:0] op, input logic [7:0] ad, input logic [15:0] dt, input int n);
        M.send({1'h1, op, ad, dt} >> (27 - n), n, 0);
    endtask : do_cmd

    task automatic expect_word(input logic [7:0] ad, input int lz);
        logic        st;
        logic [16:0] got;
        M.read_word(ad, lz, st, got);
        check("float after start bit", 1, st);
        check("read word", {1'h0, mem[ad]}, got);
    endtask : expect_word

    // busy: status low at once, ready inside the cycle; idle: pin keeps floating
    task automatic expect_prog(input logic busy);
        M.poll(busy ? PROG + 500 : 100, e, l, c);
        if (busy)
        begin
            check("busy status", 2'h0, {e, l});
            check("ready in time", 1, c < PROG);
        end
        else
            check("no status", 1, e);
    endtask : expect_prog

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    // hang guard
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            bad_count++;
            final_report();
        end
    end

    // main sequence
    initial
    begin
        fill(ERASED_WORD);
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'h1;
        pick();
        do_cmd(OPC_WRITE, a, d, 27);
        expect_prog(1'h0);
        do_cmd(OPC_SUB, {SUB_WR_EN, 6'h00}, 16'h0000, 11);
        pick();
        do_cmd(OPC_WRITE, a, d, 27);
        mem[a] = d;
        // first status only, so the next frame still lands while busy
        M.poll(0, e, l, c);
        check("busy after write", 2'h0, {e, l});
        do_cmd(OPC_SUB, {SUB_WR_DIS, 6'h2A}, 16'h0000, 11);
        check("float when deselected", 1, dout_en_b);
        expect_prog(1'h1);
        expect_word(a, 0);
        do_cmd(OPC_ERASE, a, 16'h0000, 11);
        mem[a] = ERASED_WORD;
        expect_prog(1'h1);
        expect_word(a, 2);
        do_cmd(OPC_WRITE, a, 16'h1234, 7);
        expect_prog(1'h0);
        pick();
        do_cmd(OPC_SUB, {SUB_PROG_ALL, a[5:0]}, d, 27);
        fill(d);
        expect_prog(1'h1);
        expect_word(~a, 0);
        do_cmd(OPC_SUB, {SUB_ERASE_ALL, 6'h3F}, 16'h0000, 11);
        fill(ERASED_WORD);
        expect_prog(1'h1);
        expect_word(a, 1);
        do_cmd(OPC_SUB, {SUB_WR_DIS, 6'h00}, 16'h0000, 11);
        do_cmd(OPC_WRITE, a, d, 27);
        expect_prog(1'h0);
        expect_word(a, 0);
        final_report();
    end
endmodule : sec_eeprom_bench
